// File: core/pah_pkg.sv
// Purpose: constants and types for the port A high pin function controller
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: ten pins, pin 16 is index 0 and pin 25 is index 9
//
// Summary of operation
// - direction register is 16-bit read/write; bits 9..0 steer pins 25..16.
// - direction bit matters only while the pin is general-purpose I/O.
// - direction 1 makes the pin an output, 0 an input.
// - direction bits 15..10 read as zero; software writes zero there.
// - direction register resets to all zeros, all pins inputs.
// - both function-select registers are 16-bit read/write.
// - select-1 bit 2 routes pin 25: 0 port, 1 address output 25.
// - select-1 bit 0 routes pin 24: 0 port, 1 address output 24.
// - select-1 bits 15..3 and bit 1 read zero; software writes zero.
// - select-2 bit 14 routes pin 23: 0 port, 1 address output 23.
// - select-2 bit 12 routes pin 22: 0 port, 1 address output 22.
// - select-2 bit 10 routes pin 21: 0 port, 1 address output 21.
// - select-2 bit 8 routes pin 20: 0 port, 1 address output 20.
// - select-2 odd bits 15..1 read zero; software writes zero.
// - select-2 bits 6,4,2,0 route pins 19..16 between port and address.
`default_nettype none

package pah_pkg;

    localparam int NUM_PINS = 10;
    localparam int ADR_W = 8;

    // ==================================================================
    // register map
    localparam logic [ADR_W-1:0] OFS_DIR = 8'h00;
    localparam logic [ADR_W-1:0] OFS_FSEL1 = 8'h04;
    localparam logic [ADR_W-1:0] OFS_FSEL2 = 8'h08;

    localparam logic [15:0] DIR_MASK = 16'h03ff;
    localparam logic [15:0] FSEL1_MASK = 16'h0005;
    localparam logic [15:0] FSEL2_MASK = 16'h5555;
    localparam logic [NUM_PINS-1:0] DIR_RESET = 10'h000;
    localparam logic [NUM_PINS-1:0] FUNC_RESET = 10'h000;

    // pins 24 and 25 take function indices from here on; select-1 bits 0 and 2 hold them
    localparam int FSEL1_FIRST_PIN = 8;
    localparam int FSEL2_PINS = 8;

    // ==================================================================
    // types
    typedef struct packed {
        logic o;
        logic oe_n;
    } pah_pin_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] dir;
        logic [NUM_PINS-1:0] func;
        logic ack;
        logic [31:0] rdata;
        logic [NUM_PINS-1:0] pin_o;
        logic [NUM_PINS-1:0] pin_oe_n;
        logic [NUM_PINS-1:0] port_in;
    } pah_state_t;

endpackage

`default_nettype wire

// File: core/pah_pin_ctrl.sv
// Purpose: direction and function-select registers for port A pins 25..16
// Assumes: single clock, Wishbone classic slave, pins sampled synchronously
// Notes: pin outputs are registered, so a register change shows one edge later
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module pah_pin_ctrl
    import pah_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [NUM_PINS-1:0] PORT_OUT_DATA_IN,
    input wire logic [NUM_PINS-1:0] EBC_ADDR_IN,
    input wire logic [NUM_PINS-1:0] PIN_IN,
    output logic [NUM_PINS-1:0] PIN_OUT,
    output logic [NUM_PINS-1:0] PIN_OE_N_OUT,
    output logic [NUM_PINS-1:0] PORT_IN_DATA_OUT
);

    // ==================================================================
    // helpers
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0] sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    function automatic logic [15:0] pack_fsel2(input logic [NUM_PINS-1:0] f);
        logic [15:0] r;
        r = 16'h0000;
        // one select bit per pin on even positions, odd ones stay zero
        for (int k = 0; k < FSEL2_PINS; k++) begin
            r[2*k] = f[k];
        end
        return r;
    endfunction

    function automatic logic [15:0] pack_fsel1(input logic [NUM_PINS-1:0] f);
        logic [15:0] r;
        r = 16'h0000;
        r[0] = f[FSEL1_FIRST_PIN];
        r[2] = f[FSEL1_FIRST_PIN+1];
        return r;
    endfunction

    // ==================================================================
    // state
    pah_state_t s_q;
    pah_state_t s_d;
    pah_pin_t pin_nxt [NUM_PINS];

    logic req;
    logic [15:0] dir_rd;
    logic [15:0] fsel1_rd;
    logic [15:0] fsel2_rd;
    logic [15:0] wr_dir;
    logic [15:0] wr_fsel1;
    logic [15:0] wr_fsel2;

    assign req = WB_CYC_IN && WB_STB_IN && !s_q.ack;

    assign dir_rd = {6'h00, s_q.dir} & DIR_MASK;
    assign fsel1_rd = pack_fsel1(s_q.func) & FSEL1_MASK;
    assign fsel2_rd = pack_fsel2(s_q.func) & FSEL2_MASK;

    assign wr_dir = merge16(dir_rd, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
    assign wr_fsel1 = merge16(fsel1_rd, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
    assign wr_fsel2 = merge16(fsel2_rd, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);

    // ==================================================================
    // per-pin routing
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            always_comb begin
                // each pin follows its own function-select bit
                if (s_q.func[gi]) begin
                    pin_nxt[gi].o = EBC_ADDR_IN[gi];
                    pin_nxt[gi].oe_n = 1'b0;
                end else begin
                    pin_nxt[gi].o = PORT_OUT_DATA_IN[gi];
                    pin_nxt[gi].oe_n = !s_q.dir[gi];
                end
            end
        end
    endgenerate

    // ==================================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.port_in = PIN_IN;
        for (int i = 0; i < NUM_PINS; i++) begin
            s_d.pin_o[i] = pin_nxt[i].o;
            s_d.pin_oe_n[i] = pin_nxt[i].oe_n;
        end
        if (req) begin
            // unmapped offsets answer with zero and ignore writes
            s_d.rdata = 32'h0000_0000;
            unique case (WB_ADR_IN)
                OFS_DIR: begin
                    s_d.rdata = {16'h0000, dir_rd};
                    if (WB_WE_IN) begin
                        s_d.dir = wr_dir[NUM_PINS-1:0];
                    end
                end
                OFS_FSEL1: begin
                    s_d.rdata = {16'h0000, fsel1_rd};
                    if (WB_WE_IN) begin
                        s_d.func[FSEL1_FIRST_PIN] = wr_fsel1[0];
                        s_d.func[FSEL1_FIRST_PIN+1] = wr_fsel1[2];
                    end
                end
                OFS_FSEL2: begin
                    s_d.rdata = {16'h0000, fsel2_rd};
                    if (WB_WE_IN) begin
                        for (int k = 0; k < FSEL2_PINS; k++) begin
                            s_d.func[k] = wr_fsel2[2*k];
                        end
                    end
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s_q <= '0;
            s_q.dir <= DIR_RESET;
            s_q.func <= FUNC_RESET;
            // floating pads until the first edge refreshes them
            s_q.pin_oe_n <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_ACK_OUT = s_q.ack;
    assign WB_DAT_OUT = s_q.rdata;
    assign PIN_OUT = s_q.pin_o;
    assign PIN_OE_N_OUT = s_q.pin_oe_n;
    assign PORT_IN_DATA_OUT = s_q.port_in;

    // ==================================================================
    // assertions
    sequence s_read(logic [ADR_W-1:0] a);
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == a;
    endsequence

    sequence s_write_full(logic [ADR_W-1:0] a);
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_WE_IN && WB_ADR_IN == a
            && WB_SEL_IN[1:0] == 2'b11;
    endsequence

    sequence s_ack_pulse;
        WB_ACK_OUT ##1 !WB_ACK_OUT;
    endsequence

    AST_ACK_ONE_CYCLE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> s_ack_pulse)
        else $error("ack not a single pulse one cycle after request");

    AST_DIR_READ: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_read(OFS_DIR) |=> WB_DAT_OUT[31:10] == 22'h000000
            && WB_DAT_OUT[9:0] == $past(s_q.dir))
        else $error("direction read value or reserved bits wrong");

    AST_FSEL1_RESERVED: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_read(OFS_FSEL1) |=> (WB_DAT_OUT & ~{16'h0000, FSEL1_MASK}) == 32'h0
            && WB_DAT_OUT[2] == $past(s_q.func[9]) && WB_DAT_OUT[0] == $past(s_q.func[8]))
        else $error("select-1 read value wrong");

    AST_FSEL2_RESERVED: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_read(OFS_FSEL2) |=> (WB_DAT_OUT & ~{16'h0000, FSEL2_MASK}) == 32'h0
            && WB_DAT_OUT[14] == $past(s_q.func[7]) && WB_DAT_OUT[0] == $past(s_q.func[0]))
        else $error("select-2 read value wrong");

    AST_DIR_WRITE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_DIR) |=> s_q.dir == $past(WB_DAT_IN[9:0]))
        else $error("direction write not stored");

    AST_FSEL2_WRITE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_FSEL2) |=> s_q.func[7] == $past(WB_DAT_IN[14])
            && s_q.func[4] == $past(WB_DAT_IN[8]) && s_q.func[3] == $past(WB_DAT_IN[6]))
        else $error("select-2 write not stored at even bits");

    AST_FUNC_IGNORES_DIR: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        1'b1 |=> (PIN_OE_N_OUT & $past(s_q.func)) == 10'h000
            && (PIN_OUT & $past(s_q.func)) == ($past(EBC_ADDR_IN) & $past(s_q.func)))
        else $error("address-function pin not driven from bus controller");

    AST_GPIO_DIRECTION: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        1'b1 |=> (~PIN_OE_N_OUT & ~$past(s_q.func)) == ($past(s_q.dir) & ~$past(s_q.func)))
        else $error("port pin enable does not follow direction");

    AST_IDLE_STABLE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        !(WB_CYC_IN && WB_STB_IN) [*2] |-> $stable(s_q.func) && $stable(s_q.dir))
        else $error("registers changed without a bus write");

    // low lane only, upper direction bits must survive
    sequence s_write_low(logic [ADR_W-1:0] a);
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_WE_IN && WB_ADR_IN == a
            && WB_SEL_IN[1:0] == 2'b01;
    endsequence

    sequence s_unmapped;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_ADR_IN != OFS_DIR
            && WB_ADR_IN != OFS_FSEL1 && WB_ADR_IN != OFS_FSEL2;
    endsequence

    AST_ACK_NEEDS_REQ: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        !(WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> !WB_ACK_OUT)
        else $error("ack given without a pending request");

    AST_UPPER_HALF_ZERO: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        WB_ACK_OUT |-> WB_DAT_OUT[31:16] == 16'h0000)
        else $error("read data bits 31..16 not zero");

    AST_FSEL1_PIN25: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_FSEL1) |=> s_q.func[9] == $past(WB_DAT_IN[2])
            && s_q.func[7:0] == $past(s_q.func[7:0]))
        else $error("select-1 bit 2 not stored or lower pins disturbed");

    AST_FSEL1_PIN24: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_FSEL1) |=> s_q.func[8] == $past(WB_DAT_IN[0]))
        else $error("select-1 bit 0 not stored");

    AST_FSEL2_PIN22: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_FSEL2) |=> s_q.func[6] == $past(WB_DAT_IN[12]))
        else $error("select-2 bit 12 not stored");

    AST_FSEL2_PIN21: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_FSEL2) |=> s_q.func[5] == $past(WB_DAT_IN[10]))
        else $error("select-2 bit 10 not stored");

    AST_FSEL2_LOW_PINS: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_full(OFS_FSEL2) |=> s_q.func[2] == $past(WB_DAT_IN[4])
            && s_q.func[1] == $past(WB_DAT_IN[2]) && s_q.func[0] == $past(WB_DAT_IN[0])
            && s_q.func[9:8] == $past(s_q.func[9:8]))
        else $error("select-2 low pins not stored or pins 25..24 disturbed");

    AST_DIR_LANE_KEEP: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_write_low(OFS_DIR) |=> s_q.dir[9:8] == $past(s_q.dir[9:8])
            && s_q.dir[7:0] == $past(WB_DAT_IN[7:0]))
        else $error("direction lane write wrong");

    AST_UNMAPPED_READ_ZERO: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_unmapped |=> WB_DAT_OUT == 32'h0000_0000)
        else $error("unmapped offset returned nonzero data");

    AST_UNMAPPED_NO_WRITE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        s_unmapped |=> $stable(s_q.func) && $stable(s_q.dir))
        else $error("unmapped offset changed a register");

    // output pin value
    // gated by the sampled reset so the reset-valued outputs are not judged
    AST_GPIO_OUT_VALUE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        RSTN_IN |=> (PIN_OUT & ~$past(s_q.func))
            == ($past(PORT_OUT_DATA_IN) & ~$past(s_q.func)))
        else $error("port pin output value not from port data");

    AST_PORT_IN_SAMPLE: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        RSTN_IN |=> PORT_IN_DATA_OUT == $past(PIN_IN))
        else $error("pad input not registered to port data");

    AST_RESET_DIR: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        $rose(RSTN_IN) |-> s_q.dir == DIR_RESET && PIN_OE_N_OUT == 10'h3ff)
        else $error("direction or pad enable not at reset value");

    AST_RESET_FUNC: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
        $rose(RSTN_IN) |-> s_q.func == FUNC_RESET)
        else $error("function select not at reset value");

endmodule // pah_pin_ctrl

`default_nettype wire

// File: sim/test_port_a_high_pin_function_ctrl.sv
// Purpose: self-checking bench for the port A high pin function controller
// Assumes: one clock, registers reached over classic Wishbone
// Notes: pins are judged two edges after the write that changes them
`timescale 1ns/1ps
`default_nettype none

module test_port_a_high_pin_function_ctrl import pah_pkg::*;;
    // ==========================================================
    // stimulus and observed signals
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [ADR_W-1:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [NUM_PINS-1:0] port_out = 10'h155;
    logic [NUM_PINS-1:0] ebc = 10'h2aa;
    logic [NUM_PINS-1:0] pin_in = 10'h000;
    logic [NUM_PINS-1:0] pin_out, pin_oe_n, port_in;
    int n_mismatch = 0;
    int compares = 0;

    always #2 clk = ~clk;

    pah_pin_ctrl dut (.CLK_IN(clk), .RSTN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PORT_OUT_DATA_IN(port_out),
        .EBC_ADDR_IN(ebc), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE_N_OUT(pin_oe_n), .PORT_IN_DATA_OUT(port_in));

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until the rising edge that samples ack high; data taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (ack !== 1'h1) n_mismatch++;
        r = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        bus(1'h1, a, d, s, r);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, 4'hf, r);
        check(r, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd_check(OFS_DIR, 32'h0);
        rd_check(OFS_FSEL1, 32'h0);
        rd_check(OFS_FSEL2, 32'h0);
        check(32'(pin_oe_n), 32'h3ff);
    endtask

    task automatic t_regs();
        wr(OFS_DIR, 32'h000003ff, 4'hf);
        rd_check(OFS_DIR, 32'h3ff);
        wr(OFS_FSEL1, 32'h00000005, 4'hf);
        rd_check(OFS_FSEL1, 32'h5);
        wr(OFS_FSEL2, 32'h00005555, 4'hf);
        rd_check(OFS_FSEL2, 32'h5555);
        wr(8'h0c, 32'hffffffff, 4'hf);
        rd_check(8'h0c, 32'h0);
        // only the low lane is enabled, upper byte must survive
        wr(OFS_DIR, 32'h0, 4'h1);
        rd_check(OFS_DIR, 32'h300);
        wr(OFS_DIR, 32'h0, 4'hf);
        wr(OFS_FSEL1, 32'h0, 4'hf);
        wr(OFS_FSEL2, 32'h0, 4'hf);
    endtask

    task automatic t_dir();
        wr(OFS_DIR, 32'h0f0, 4'hf);
        settle();
        check(32'(pin_oe_n), 32'h30f);
        check(32'(pin_out & 10'h0f0), 32'h050);
        wr(OFS_DIR, 32'h0, 4'hf);
        settle();
        check(32'(pin_oe_n), 32'h3ff);
    endtask

    // walking one function bit with every direction bit at input
    task automatic t_func();
        logic [NUM_PINS-1:0] m;
        logic [15:0] f1, f2;
        for (int i = 0; i < NUM_PINS; i++) begin
            m = 10'h001 << i;
            f1 = {13'h0, m[9], 1'h0, m[8]};
            f2 = 16'h0;
            for (int k = 0; k < 8; k++) f2[2*k] = m[k];
            wr(OFS_FSEL1, 32'(f1), 4'hf);
            wr(OFS_FSEL2, 32'(f2), 4'hf);
            rd_check(OFS_FSEL1, 32'(f1));
            settle();
            check(32'(pin_oe_n), 32'(10'h3ff ^ m));
            check(32'(pin_out & m), 32'(ebc & m));
        end
        wr(OFS_FSEL1, 32'h0, 4'hf);
        wr(OFS_FSEL2, 32'h0, 4'hf);
    endtask

    task automatic t_in();
        pin_in <= 10'h3a5;
        settle();
        check(32'(port_in), 32'h3a5);
    endtask

    // mid-run reset with registers loaded brings every pin back to port input
    task automatic t_rerst();
        wr(OFS_DIR, 32'h000003ff, 4'hf);
        wr(OFS_FSEL1, 32'h00000005, 4'hf);
        wr(OFS_FSEL2, 32'h00005555, 4'hf);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        check(32'(pin_oe_n), 32'h3ff);
        rd_check(OFS_DIR, 32'h0);
        rd_check(OFS_FSEL1, 32'h0);
        rd_check(OFS_FSEL2, 32'h0);
    endtask

    // ==========================================================
    // run control
    task automatic summarize();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_regs();
        t_dir();
        t_func();
        t_in();
        t_rerst();
        summarize();
    end
endmodule // test_port_a_high_pin_function_ctrl

`default_nettype wire
